// [hdl/timer0_core.sv]
`timescale 1ns/1ns
`default_nettype none
// Contract
// - A count_value write suppresses the compare match on the next timer tick.
// - The 8-bit compare_value is compared with the counter every cycle.
// - Compare interrupt needs compare_irq_enable, global enable and compare_flag.
// - Overflow interrupt needs overflow_irq_enable, global enable and overflow_flag.
// - compare_flag, flag bit 1, sets when counter equals compare_value.
// - compare_flag clears on vector execution or a written one.
// - overflow_flag, flag bit 0, sets on overflow; clears like compare_flag.
// - In phase correct mode overflow_flag sets on reversal at zero.
// - One prescaler serves both timers, each with its own clock select.
// - Code 1 ticks every clock; other internal codes tap 8, 64, 256, 1024.
// - Prescaler runs freely; first prescaled count lands 1 to N+1 clocks later.
// - Prescaler reset restarts the divided phase for both timers.
// - Count pin sampled each clock; only the synchronised level feeds detection.
// - Synchroniser is a latch open while clock high, then rising-edge flops.
// - One tick per rising edge for code 7, per falling edge for code 6.
// - Pin edge to counter update takes 2.5 to 3.5 clock cycles.
// - External pin pulses never pass through the prescaler.
// - Writing one to prescaler_reset_bit resets prescaler; self-clears, reads zero.
// - Clock select zero leaves the counter stopped.
module timer0_core (
   input  wire logic                         clk_sys_i,
   input  wire logic                         sys_rst_i,
   input  wire logic [timer0_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]                   reg_wdata_i,
   input  wire logic                         reg_write_i,
   input  wire logic                         reg_read_i,
   output logic      [7:0]                   reg_rdata_o,
   input  wire logic                         global_irq_enable_i,
   input  wire logic                         compare_vector_ack_i,
   input  wire logic                         overflow_vector_ack_i,
   input  wire logic [2:0]                   timer1_clock_select_i,
   input  wire logic                         external_count_pin_i,
   output logic                              compare_irq_o,
   output logic                              overflow_irq_o,
   output logic                              timer1_tick_o,
   output logic                              waveform_output_pin_o
);

   // ***********************************
   // Register port decode
   // ***********************************
   logic [7:0] control_q;
   logic [7:0] count_value_q;
   logic [7:0] compare_value_q;
   logic [7:0] mask_q;
   logic [1:0] flags_q;
   logic       wr_control_w;
   logic       wr_count_w;
   logic       wr_compare_w;
   logic       wr_mask_w;
   logic       wr_flags_w;
   logic       wr_special_w;
   logic       psr_reset_w;

   assign wr_control_w = reg_write_i && (reg_addr_i == timer0_pkg::IDX_CONTROL);
   assign wr_count_w   = reg_write_i && (reg_addr_i == timer0_pkg::IDX_COUNT);
   assign wr_compare_w = reg_write_i && (reg_addr_i == timer0_pkg::IDX_COMPARE);
   assign wr_mask_w    = reg_write_i && (reg_addr_i == timer0_pkg::IDX_MASK);
   assign wr_flags_w   = reg_write_i && (reg_addr_i == timer0_pkg::IDX_FLAGS);
   assign wr_special_w = reg_write_i && (reg_addr_i == timer0_pkg::IDX_SPECIAL);
   // Only a written one acts; the bit itself is never stored
   assign psr_reset_w  = wr_special_w && reg_wdata_i[timer0_pkg::BIT_PSR];

   // Control fields
   logic [2:0]        clock_select_w;
   logic [1:0]        com_w;
   timer0_pkg::mode_t mode_w;

   assign clock_select_w = control_q[2:0];
   assign com_w          = control_q[timer0_pkg::COM_LSB +: 2];
   assign mode_w         = timer0_pkg::mode_t'({control_q[timer0_pkg::BIT_WGM1],
                                               control_q[timer0_pkg::BIT_WGM0]});

   // ***********************************
   // Shared free-running prescaler
   // ***********************************
   logic [timer0_pkg::PRESC_W-1:0] presc_q;

   // Runs regardless of either clock select; reset restarts both timers
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || psr_reset_w) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + 1'b1;
      end
   end

   logic tap8_w;
   logic tap64_w;
   logic tap256_w;
   logic tap1024_w;

   // Each tap pulses once per its period, on the last count of it
   assign tap8_w    = (presc_q & timer0_pkg::TAP8_MASK) == timer0_pkg::TAP8_MASK;
   assign tap64_w   = (presc_q & timer0_pkg::TAP64_MASK) == timer0_pkg::TAP64_MASK;
   assign tap256_w  = (presc_q & timer0_pkg::TAP256_MASK) == timer0_pkg::TAP256_MASK;
   assign tap1024_w = (presc_q & timer0_pkg::TAP1024_MASK) == timer0_pkg::TAP1024_MASK;

   // Tap choice per clock select; external codes give no internal tick
   function automatic logic internal_tick(input logic [2:0] cs,
                                          input logic t8, input logic t64,
                                          input logic t256, input logic t1024);
      logic r;
      r = 1'b0;
      unique case (cs)
         timer0_pkg::CS_DIRECT:  r = 1'b1;
         timer0_pkg::CS_DIV8:    r = t8;
         timer0_pkg::CS_DIV64:   r = t64;
         timer0_pkg::CS_DIV256:  r = t256;
         timer0_pkg::CS_DIV1024: r = t1024;
         default:                r = 1'b0;
      endcase
      return r;
   endfunction : internal_tick

   // Second timer keeps its own select on the same taps
   assign timer1_tick_o = internal_tick(timer1_clock_select_i, tap8_w, tap64_w,
                                        tap256_w, tap1024_w);

   // ***********************************
   // External count pin synchroniser
   // ***********************************
   logic pin_lat_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;

   // Latch open in the high phase gives the half-cycle part of the delay
   always_latch begin
      if (clk_sys_i) begin
         pin_lat_q <= external_count_pin_i;
      end
   end

   // s1 feeds only s2; detection looks at s2 and its delayed copy
   always_ff @(posedge clk_sys_i) begin
      pin_s1_q <= pin_lat_q;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
   end

   logic ext_rise_w;
   logic ext_fall_w;
   logic ext_tick_w;

   assign ext_rise_w = pin_s2_q && !pin_s3_q;
   assign ext_fall_w = !pin_s2_q && pin_s3_q;
   // Pin edges bypass the prescaler entirely
   assign ext_tick_w = ((clock_select_w == timer0_pkg::CS_EXT_RISE) && ext_rise_w) ||
                       ((clock_select_w == timer0_pkg::CS_EXT_FALL) && ext_fall_w);

   // ***********************************
   // Timer tick and compare
   // ***********************************
   logic timer_tick_w;
   logic match_w;
   logic cmp_evt_w;
   logic ovf_evt_w;
   logic block_q;
   logic down_q;

   assign timer_tick_w = internal_tick(clock_select_w, tap8_w, tap64_w, tap256_w,
                                       tap1024_w) || ext_tick_w;
   assign match_w      = (count_value_q == compare_value_q);
   assign cmp_evt_w    = timer_tick_w && match_w && !block_q;

   // Overflow: wrap at MAX, or reversal at zero in phase correct mode
   assign ovf_evt_w = timer_tick_w &&
      ((mode_w == timer0_pkg::MODE_PHASE_PWM) ?
          (down_q && (count_value_q == timer0_pkg::COUNT_BOTTOM)) :
          (count_value_q == timer0_pkg::COUNT_MAX));

   // A count write arms the block until the next tick consumes it
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         block_q <= 1'b0;
      end else if (wr_count_w) begin
         block_q <= 1'b1;
      end else if (timer_tick_w) begin
         block_q <= 1'b0;
      end
   end

   // ***********************************
   // Counter
   // ***********************************
   logic [7:0] count_d;
   logic       down_d;

   // Next count per mode; the write path wins over counting
   always_comb begin
      count_d = count_value_q;
      down_d  = down_q;
      if (timer_tick_w) begin
         unique case (mode_w)
            timer0_pkg::MODE_PHASE_PWM: begin
               if (!down_q && (count_value_q == timer0_pkg::COUNT_MAX)) begin
                  down_d  = 1'b1;
                  count_d = count_value_q - timer0_pkg::COUNT_ONE;
               end else if (down_q && (count_value_q == timer0_pkg::COUNT_BOTTOM)) begin
                  down_d  = 1'b0;
                  count_d = timer0_pkg::COUNT_ONE;
               end else if (down_q) begin
                  count_d = count_value_q - timer0_pkg::COUNT_ONE;
               end else begin
                  count_d = count_value_q + timer0_pkg::COUNT_ONE;
               end
            end
            timer0_pkg::MODE_CTC: begin
               count_d = match_w ? timer0_pkg::COUNT_BOTTOM
                                 : count_value_q + timer0_pkg::COUNT_ONE;
            end
            default: begin
               count_d = count_value_q + timer0_pkg::COUNT_ONE;
            end
         endcase
      end
      if (wr_count_w) begin
         count_d = reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         count_value_q <= timer0_pkg::RST_BYTE;
         down_q        <= 1'b0;
      end else begin
         count_value_q <= count_d;
         down_q        <= down_d;
      end
   end

   // ***********************************
   // Software registers
   // ***********************************
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         control_q       <= timer0_pkg::RST_BYTE;
         compare_value_q <= timer0_pkg::RST_BYTE;
         mask_q          <= timer0_pkg::RST_BYTE;
      end else begin
         if (wr_control_w) begin
            control_q <= reg_wdata_i;
         end
         if (wr_compare_w) begin
            compare_value_q <= reg_wdata_i;
         end
         if (wr_mask_w) begin
            mask_q <= reg_wdata_i;
         end
      end
   end

   // ***********************************
   // Interrupt flags
   // ***********************************
   logic [1:0] flag_set_w;
   logic [1:0] flag_clr_w;

   assign flag_set_w[timer0_pkg::BIT_OVF] = ovf_evt_w;
   assign flag_set_w[timer0_pkg::BIT_CMP] = cmp_evt_w;
   // Zero bits in a flag write clear nothing
   assign flag_clr_w[timer0_pkg::BIT_OVF] = overflow_vector_ack_i ||
      (wr_flags_w && reg_wdata_i[timer0_pkg::BIT_OVF]);
   assign flag_clr_w[timer0_pkg::BIT_CMP] = compare_vector_ack_i ||
      (wr_flags_w && reg_wdata_i[timer0_pkg::BIT_CMP]);

   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         flags_q <= '0;
      end else begin
         flags_q <= flag_set_w | (flags_q & ~flag_clr_w);
      end
   end

   // Requests gated by enables and the global enable
   assign compare_irq_o  = global_irq_enable_i && mask_q[timer0_pkg::BIT_CMP] &&
                           flags_q[timer0_pkg::BIT_CMP];
   assign overflow_irq_o = global_irq_enable_i && mask_q[timer0_pkg::BIT_OVF] &&
                           flags_q[timer0_pkg::BIT_OVF];

   // ***********************************
   // Waveform output
   // ***********************************
   logic wave_q;
   logic pwm_mode_w;
   logic bottom_w;

   assign pwm_mode_w = (mode_w == timer0_pkg::MODE_FAST_PWM) ||
                       (mode_w == timer0_pkg::MODE_PHASE_PWM);
   assign bottom_w   = timer_tick_w && (count_value_q == timer0_pkg::COUNT_MAX) &&
                       (mode_w == timer0_pkg::MODE_FAST_PWM);

   // PWM modes use only the clear/set codes; toggle is reserved there
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wave_q <= 1'b0;
      end else if (cmp_evt_w && !pwm_mode_w) begin
         unique case (com_w)
            timer0_pkg::COM_TOGGLE: wave_q <= !wave_q;
            timer0_pkg::COM_CLEAR:  wave_q <= 1'b0;
            timer0_pkg::COM_SET:    wave_q <= 1'b1;
            default:                wave_q <= wave_q;
         endcase
      end else if (cmp_evt_w && com_w[1]) begin
         wave_q <= com_w[0] ^ down_q;
      end else if (bottom_w && com_w[1]) begin
         wave_q <= !com_w[0];
      end
   end

   assign waveform_output_pin_o = wave_q;

   // ***********************************
   // Read data
   // ***********************************
   logic [7:0] rd_mux_w;
   logic [7:0] rdata_q;

   // Special register reads zero: the reset bit never holds a value
   assign rd_mux_w =
      (reg_addr_i == timer0_pkg::IDX_CONTROL) ? control_q :
      (reg_addr_i == timer0_pkg::IDX_COUNT)   ? count_value_q :
      (reg_addr_i == timer0_pkg::IDX_COMPARE) ? compare_value_q :
      (reg_addr_i == timer0_pkg::IDX_MASK)    ? mask_q :
      (reg_addr_i == timer0_pkg::IDX_FLAGS)   ? {6'h00, flags_q} :
      timer0_pkg::RST_BYTE;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_q <= timer0_pkg::RST_BYTE;
      end else if (reg_read_i) begin
         rdata_q <= rd_mux_w;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ***********************************
   // Assertions
   // ***********************************
   sequence s_count_write_then_tick;
      wr_count_w ##1 (timer_tick_w && !wr_count_w);
   endsequence

   a_write_blocks_match: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_count_write_then_tick |=> !$rose(flags_q[timer0_pkg::BIT_CMP]))
      else $error("compare flag rose on the tick after a count write");

   a_compare_irq_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $rose(compare_irq_o) |-> global_irq_enable_i && mask_q[timer0_pkg::BIT_CMP])
      else $error("compare request without its enables");

   a_overflow_irq_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      overflow_irq_o |-> flags_q[timer0_pkg::BIT_OVF] && global_irq_enable_i)
      else $error("overflow request without flag or global enable");

   a_compare_flag_set: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (timer_tick_w && match_w && !block_q) |=> flags_q[timer0_pkg::BIT_CMP])
      else $error("compare flag not set on match");

   a_compare_flag_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (compare_vector_ack_i && !cmp_evt_w) |=> !flags_q[timer0_pkg::BIT_CMP])
      else $error("compare flag not cleared by vector");

   a_overflow_wrap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (timer_tick_w && mode_w == timer0_pkg::MODE_NORMAL && !wr_count_w &&
       count_value_q == timer0_pkg::COUNT_MAX) |=> flags_q[timer0_pkg::BIT_OVF] &&
       count_value_q == timer0_pkg::COUNT_BOTTOM)
      else $error("normal mode wrap did not flag overflow");

   a_phase_overflow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (mode_w == timer0_pkg::MODE_PHASE_PWM && $rose(flags_q[timer0_pkg::BIT_OVF])) |->
      $past(count_value_q) == timer0_pkg::COUNT_BOTTOM)
      else $error("phase correct overflow away from zero");

   a_div8_tap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clock_select_w == timer0_pkg::CS_DIV8 && timer_tick_w) |->
      ##1 !timer_tick_w [*7])
      else $error("divide by 8 ticks too close");

   a_stopped_timer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clock_select_w == timer0_pkg::CS_STOP && !wr_count_w && !wr_control_w) |=>
      $stable(count_value_q))
      else $error("counter moved with no clock source");

   a_ext_rise_delay: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clock_select_w == timer0_pkg::CS_EXT_RISE && $rose(pin_s1_q)) |=>
      timer_tick_w)
      else $error("rising pin edge gave no tick");

   a_special_reads_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (reg_read_i && reg_addr_i == timer0_pkg::IDX_SPECIAL) |=> reg_rdata_o == 8'h00)
      else $error("special register read not zero");

   a_presc_restart: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      psr_reset_w |=> presc_q == '0)
      else $error("prescaler not restarted");

endmodule : timer0_core
`default_nettype wire

// [pkg/timer0_pkg.sv]
`default_nettype none
package timer0_pkg;
   // ***********************************
   // Register indices on the plain port
   // ***********************************
   localparam int          ADDR_W         = 3;
   localparam logic [2:0]  IDX_CONTROL    = 3'h0;
   localparam logic [2:0]  IDX_COUNT      = 3'h1;
   localparam logic [2:0]  IDX_COMPARE    = 3'h2;
   localparam logic [2:0]  IDX_MASK       = 3'h3;
   localparam logic [2:0]  IDX_FLAGS      = 3'h4;
   localparam logic [2:0]  IDX_SPECIAL    = 3'h5;

   // ***********************************
   // Field positions and reset values
   // ***********************************
   localparam int          BIT_OVF        = 0;
   localparam int          BIT_CMP        = 1;
   localparam int          BIT_PSR        = 0;
   localparam int          BIT_WGM0       = 6;
   localparam int          BIT_WGM1       = 3;
   localparam int          COM_LSB        = 4;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [7:0]  COUNT_MAX      = 8'hFF;
   localparam logic [7:0]  COUNT_BOTTOM   = 8'h00;
   localparam logic [7:0]  COUNT_ONE      = 8'h01;

   // ***********************************
   // Clock select codes and prescaler
   // ***********************************
   localparam logic [2:0]  CS_STOP        = 3'h0;
   localparam logic [2:0]  CS_DIRECT      = 3'h1;
   localparam logic [2:0]  CS_DIV8        = 3'h2;
   localparam logic [2:0]  CS_DIV64       = 3'h3;
   localparam logic [2:0]  CS_DIV256      = 3'h4;
   localparam logic [2:0]  CS_DIV1024     = 3'h5;
   localparam logic [2:0]  CS_EXT_FALL    = 3'h6;
   localparam logic [2:0]  CS_EXT_RISE    = 3'h7;
   localparam int          PRESC_W        = 10;
   localparam logic [9:0]  TAP8_MASK      = 10'h007;
   localparam logic [9:0]  TAP64_MASK     = 10'h03F;
   localparam logic [9:0]  TAP256_MASK    = 10'h0FF;
   localparam logic [9:0]  TAP1024_MASK   = 10'h3FF;

   // ***********************************
   // Counting modes and compare outputs
   // ***********************************
   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_PHASE_PWM, MODE_CTC, MODE_FAST_PWM
   } mode_t;
   localparam logic [1:0]  COM_OFF        = 2'h0;
   localparam logic [1:0]  COM_TOGGLE     = 2'h1;
   localparam logic [1:0]  COM_CLEAR      = 2'h2;
   localparam logic [1:0]  COM_SET        = 2'h3;
endpackage : timer0_pkg
`default_nettype wire

// [verif/ext_count_source.sv]
`timescale 1ns/1ns
`default_nettype none
// ************************************
// External clock source on count pin
// ************************************
module ext_count_source #(
   parameter int HALF_CYCLES = 3
) (
   input  wire logic       clk_sys_i,
   input  wire logic       start_i,
   input  wire logic [7:0] pulses_i,
   output logic            pin_o,
   output logic            busy_o
);
   // Burst of pulses per start; pin rests low between bursts
   initial begin
      pin_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_sys_i);
         if (start_i === 1'b1) begin
            busy_o <= 1'b1;
            repeat (pulses_i) begin
               // Half periods of several clocks, well under the clock rate
               repeat (HALF_CYCLES) @(posedge clk_sys_i);
               pin_o <= #7 1'b1;
               repeat (HALF_CYCLES) @(posedge clk_sys_i);
               pin_o <= #7 1'b0;
            end
            // Pin goes low 7 ns after the last edge and busy drops on the next edge, three edges before that fall is counted
            @(posedge clk_sys_i);
            busy_o <= 1'b0;
         end
      end
   end
endmodule : ext_count_source
`default_nettype wire

// [verif/test_timer0_flags_prescaler_extclk.sv]
`timescale 1ns/1ns
`default_nettype none
module test_timer0_flags_prescaler_extclk;
   // ********************
   // Wiring
   // ********************
   logic       clk_sys_i, sys_rst_i, reg_write_i, reg_read_i;
   logic [2:0] reg_addr_i, t1_cs;
   logic [7:0] reg_wdata_i, reg_rdata_o, pulses;
   logic       gie, cmp_ack, ovf_ack, pin, cmp_irq, ovf_irq, t1_tick, start, busy, wave;
   int         miscompares, checked, n;

   timer0_core dut (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .global_irq_enable_i(gie), .compare_vector_ack_i(cmp_ack),
      .overflow_vector_ack_i(ovf_ack), .timer1_clock_select_i(t1_cs),
      .external_count_pin_i(pin), .compare_irq_o(cmp_irq), .overflow_irq_o(ovf_irq),
      .timer1_tick_o(t1_tick), .waveform_output_pin_o(wave));

   ext_count_source #(.HALF_CYCLES(3)) source (
      .clk_sys_i(clk_sys_i), .start_i(start), .pulses_i(pulses), .pin_o(pin), .busy_o(busy));

   // ********************
   // Bus and compare tasks
   // ********************
   task automatic fail(input string msg);
      miscompares++;
      $display("ERROR %0t ns: %s", $time, msg);
   endtask : fail

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
         fail($sformatf("got %h expected %h", got, exp));
   endtask : chk

   // Tick counts may be off by one edge at window borders
   task automatic chk_rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi)
         fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
   endtask : chk_rng

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_read_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask : rd

   // Interrupt outputs are combinational, so let edge updates land
   task automatic irqs(input logic [1:0] exp);
      #1;
      chk({6'h00, cmp_irq, ovf_irq}, {6'h00, exp});
   endtask : irqs

   task automatic end_of_test;
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   // ********************
   // Scenarios
   // ********************
   task automatic t_reset_regs;
      for (int i = 0; i < 8; i++)
         rd(3'(i), 8'h00);
      wr(timer0_pkg::IDX_COMPARE, 8'h5A);
      rd(timer0_pkg::IDX_COMPARE, 8'h5A);
      wr(timer0_pkg::IDX_SPECIAL, 8'h01);
      rd(timer0_pkg::IDX_SPECIAL, 8'h00);
      wr(3'h6, 8'hFF);
      rd(3'h6, 8'h00);
      wr(timer0_pkg::IDX_COUNT, 8'h37);
      repeat (20) @(posedge clk_sys_i);
      rd(timer0_pkg::IDX_COUNT, 8'h37);
   endtask : t_reset_regs

   task automatic t_overflow;
      wr(timer0_pkg::IDX_COUNT, 8'hFD);
      wr(timer0_pkg::IDX_CONTROL, {5'h00, timer0_pkg::CS_DIRECT});
      repeat (4) @(posedge clk_sys_i);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_FLAGS, 8'h01);
      irqs(2'b00);
      wr(timer0_pkg::IDX_MASK, 8'h01);
      irqs(2'b01);
      @(posedge clk_sys_i);
      gie <= 1'b0;
      irqs(2'b00);
      @(posedge clk_sys_i);
      gie <= 1'b1;
      wr(timer0_pkg::IDX_FLAGS, 8'h00);
      rd(timer0_pkg::IDX_FLAGS, 8'h01);
      @(posedge clk_sys_i);
      ovf_ack <= 1'b1;
      @(posedge clk_sys_i);
      ovf_ack <= 1'b0;
      rd(timer0_pkg::IDX_FLAGS, 8'h00);
      irqs(2'b00);
      // Phase correct: past the top with no flag, then down to zero
      wr(timer0_pkg::IDX_COUNT, 8'hFE);
      wr(timer0_pkg::IDX_CONTROL, 8'h41);
      repeat (100) @(posedge clk_sys_i);
      rd(timer0_pkg::IDX_FLAGS, 8'h00);
      repeat (200) @(posedge clk_sys_i);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_FLAGS, 8'h03);
      wr(timer0_pkg::IDX_FLAGS, 8'h01);
      rd(timer0_pkg::IDX_FLAGS, 8'h02);
      wr(timer0_pkg::IDX_FLAGS, 8'h02);
      rd(timer0_pkg::IDX_FLAGS, 8'h00);
   endtask : t_overflow

   // Match passes by counting, then a count write onto the match value
   task automatic t_compare;
      wr(timer0_pkg::IDX_COMPARE, 8'h10);
      wr(timer0_pkg::IDX_COUNT, 8'h08);
      wr(timer0_pkg::IDX_MASK, 8'h02);
      // Toggle output mode so every unblocked match also shows on the pin
      wr(timer0_pkg::IDX_CONTROL, 8'h11);
      repeat (12) @(posedge clk_sys_i);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_FLAGS, 8'h02);
      irqs(2'b10);
      chk({7'h00, wave}, 8'h01);
      @(posedge clk_sys_i);
      cmp_ack <= 1'b1;
      @(posedge clk_sys_i);
      cmp_ack <= 1'b0;
      rd(timer0_pkg::IDX_FLAGS, 8'h00);
      irqs(2'b00);
      wr(timer0_pkg::IDX_COUNT, 8'h80);
      wr(timer0_pkg::IDX_CONTROL, 8'h11);
      wr(timer0_pkg::IDX_COUNT, 8'h10);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_FLAGS, 8'h00);
      chk({7'h00, wave}, 8'h01);
   endtask : t_compare

   task automatic t_prescaler;
      int exp [8] = '{0, 2048, 256, 32, 8, 2, 0, 0};
      int cnt;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys_i);
         t1_cs <= 3'(c);
         cnt = 0;
         repeat (2048) begin
            @(negedge clk_sys_i);
            if (t1_tick === 1'b1)
               cnt++;
         end
         chk_rng(cnt, exp[c] - 1, exp[c] + 1);
      end
      @(posedge clk_sys_i);
      t1_cs <= timer0_pkg::CS_DIV8;
      wr(timer0_pkg::IDX_SPECIAL, 8'h01);
      for (cnt = 1; cnt < 10; cnt++) begin
         @(negedge clk_sys_i);
         if (t1_tick === 1'b1)
            break;
      end
      chk_rng(cnt, 8, 8);
      rd(timer0_pkg::IDX_COUNT, 8'h12);
      // Prescaler phase is known after the restart: two taps fall in the window
      wr(timer0_pkg::IDX_CONTROL, {5'h00, timer0_pkg::CS_DIV8});
      repeat (16) @(posedge clk_sys_i);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_COUNT, 8'h14);
   endtask : t_prescaler

   // Five pulses must give five counts, undivided
   task automatic t_external(input logic [2:0] cs);
      wr(timer0_pkg::IDX_COUNT, 8'h00);
      wr(timer0_pkg::IDX_CONTROL, {5'h00, cs});
      @(posedge clk_sys_i);
      pulses <= 8'h05;
      start  <= 1'b1;
      @(posedge clk_sys_i);
      start  <= 1'b0;
      // Busy rises on the same edge that start is seen
      @(negedge clk_sys_i);
      for (n = 0; n < 200 && busy !== 1'b0; n++)
         @(negedge clk_sys_i);
      if (n == 200) begin
         fail("external source hung");
         end_of_test();
      end
      repeat (3) @(posedge clk_sys_i);
      wr(timer0_pkg::IDX_CONTROL, 8'h00);
      rd(timer0_pkg::IDX_COUNT, 8'h05);
   endtask : t_external

   // ********************
   // Clock and sequence
   // ********************
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      {sys_rst_i, gie} = 2'b11;
      {reg_write_i, reg_read_i, cmp_ack, ovf_ack, start} = 5'h00;
      {reg_addr_i, t1_cs, reg_wdata_i, pulses} = 22'h000000;
      miscompares = 0;
      checked = 0;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_reset_regs();
      t_overflow();
      t_compare();
      t_prescaler();
      t_external(timer0_pkg::CS_EXT_RISE);
      t_external(timer0_pkg::CS_EXT_FALL);
      end_of_test();
   end
endmodule : test_timer0_flags_prescaler_extclk
`default_nettype wire
